/* hdl/rcp_pkg.sv */
// constants for reset sequencing, clock output and pll lock control
package rcp_pkg;
  // ==========================================================
  // register map
  localparam logic [4:0] GEN_CFG_ADDR = 5'h00;
  localparam logic [4:0] PLL_IRQ_ADDR = 5'h0E;
  localparam logic [4:0] CLK_OUT_ADDR = 5'h1B;
  localparam logic [7:0] GEN_CFG_RST = 8'h00;
  localparam logic [7:0] PLL_IRQ_RST = 8'h01;
  localparam logic [7:0] CLK_OUT_RST = 8'hBC;
  // ==========================================================
  // field positions
  localparam int CLK_EN_BIT = 7;
  localparam int CLK_DIV_HI = 6;
  localparam int CLK_DIV_LO = 2;
  localparam int LOCK_FLAG_BIT = 1;
  localparam int LOCK_PIN_EN_BIT = 0;
  localparam int BAND_HI = 4;
  localparam int BAND_LO = 3;
  localparam int TRIM_HI = 2;
  localparam int TRIM_LO = 0;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 5;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_POR_WAIT_MS = 10;
  localparam int T_MRST_HOLD_US = 100;
  localparam int T_MRST_WAIT_MS = 5;
  localparam int POR_WAIT_CYC = T_POR_WAIT_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int MRST_WAIT_CYC =
    T_MRST_WAIT_MS * 1_000_000 / CLK_PERIOD_NS;
  // least hold time rounds up
  localparam int MRST_HOLD_CYC =
    (T_MRST_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_W = 17;
  typedef enum logic [1:0] {ST_POR, ST_WAIT, ST_READY} rcp_state_t;
endpackage

/* hdl/rcp_clkdiv.sv */
// divider producing the buffered reference clock output
`timescale 1ns/1ps
module rcp_clkdiv #(
  parameter int DIV_W = 5
) (
  input wire logic clk, // reference clock
  input wire logic srst, // synchronous reset
  input wire logic en, // output enable
  input wire logic [DIV_W-1:0] div, // half period minus one
  output logic clk_out_ff // divided clock
);
  logic [DIV_W-1:0] cnt_ff;
  wire logic at_end = (cnt_ff >= div);
  // ==========================================================
  // divider
  // ratio from field
  always_ff @(posedge clk) begin
    if (srst || !en) begin
      cnt_ff <= '0;
      clk_out_ff <= 1'b0;
    end else if (at_end) begin
      cnt_ff <= '0;
      clk_out_ff <= ~clk_out_ff;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
  // ==========================================================
  // checks
  property p_div_toggle;
    @(posedge clk) disable iff (srst)
      en && cnt_ff == div && $stable(div) |=>
        (clk_out_ff != $past(clk_out_ff)) || !$past(en);
  endproperty
  a_div_toggle: assert property (p_div_toggle)
    else $error("clock output missed toggle at divider end");
  property p_div_hold;
    @(posedge clk) disable iff (srst)
      en && $past(en) && cnt_ff != '0 |-> $stable(clk_out_ff);
  endproperty
  a_div_hold: assert property (p_div_hold)
    else $error("clock output toggled mid period");
endmodule

/* hdl/rcp_top.sv */
// reset sequencing, clock output and pll lock control
`timescale 1ns/1ps
module rcp_top
  import rcp_pkg::*;
#(
  parameter int POR_WAIT = POR_WAIT_CYC,
  parameter int MRST_WAIT = MRST_WAIT_CYC
) (
  input wire logic clk, // 10 MHz reference
  input wire logic srst, // synchronous reset
  input wire logic por_active, // power-on reset in progress
  input wire logic sleep_mode, // device in sleep
  input wire logic pll_lock_in, // synthesizer lock level
  input wire logic [4:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata_ff, // read data, one cycle late
  input wire logic manual_reset_pin_in, // reset pin level
  output logic manual_reset_pin_out_ff, // reset pin drive value
  output logic manual_reset_pin_oe_ff, // reset pin drive enable
  output logic manual_reset_req_ff, // manual reset pulse
  output logic dev_ready_ff, // host may access device
  output logic buffered_clock_output, // divided reference clock
  output logic lock_indicator_pin_ff, // lock status pin
  output logic [1:0] band_select_ff, // vco band
  output logic [2:0] vco_trim_ff, // vco trim
  output logic [2:0] chip_mode_ff // operating mode field
);
  logic [7:0] clk_out_ff;
  logic [7:2] irq_cfg_ff;
  logic pll_lock_flag_ff;
  logic lock_pin_enable_ff;
  logic lock_d_ff;
  logic [9:0] hold_cnt_ff;
  logic pin_hi_d_ff;
  logic [WAIT_W-1:0] wait_cnt_ff;
  logic [WAIT_W-1:0] wait_lim_ff;
  rcp_state_t state_ff;
  rcp_state_t nxt_state;
  // ==========================================================
  // decode
  wire logic wr_gen = reg_wr && reg_addr == GEN_CFG_ADDR;
  wire logic wr_irq = reg_wr && reg_addr == PLL_IRQ_ADDR;
  wire logic wr_clk = reg_wr && reg_addr == CLK_OUT_ADDR;
  wire logic lock_rise = pll_lock_in && !lock_d_ff;
  wire logic lock_clr = wr_irq && reg_wdata[LOCK_FLAG_BIT];
  wire logic nxt_lock_flag = lock_rise || (pll_lock_flag_ff && !lock_clr);
  wire logic clk_en = clk_out_ff[CLK_EN_BIT] && !sleep_mode;
  wire logic [7:0] irq_rd =
    {irq_cfg_ff, pll_lock_flag_ff, lock_pin_enable_ff};
  wire logic [7:0] gen_rd = {chip_mode_ff, band_select_ff, vco_trim_ff};
  wire logic [7:0] nxt_rdata =
    (reg_addr == GEN_CFG_ADDR) ? gen_rd :
    (reg_addr == PLL_IRQ_ADDR) ? irq_rd :
    (reg_addr == CLK_OUT_ADDR) ? clk_out_ff : 8'h00;
  wire logic pin_hi = manual_reset_pin_in && !manual_reset_pin_oe_ff;
  wire logic mrst_done =
    pin_hi_d_ff && !pin_hi && hold_cnt_ff >= 10'(MRST_HOLD_CYC);
  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (srst) begin
      {chip_mode_ff, band_select_ff, vco_trim_ff} <= GEN_CFG_RST;
      clk_out_ff <= CLK_OUT_RST;
      irq_cfg_ff <= PLL_IRQ_RST[7:2];
      pll_lock_flag_ff <= PLL_IRQ_RST[LOCK_FLAG_BIT];
      lock_pin_enable_ff <= PLL_IRQ_RST[LOCK_PIN_EN_BIT];
      lock_d_ff <= 1'b0;
      reg_rdata_ff <= 8'h00;
    end else begin
      if (wr_gen) begin
        {chip_mode_ff, band_select_ff, vco_trim_ff} <= reg_wdata;
      end
      if (wr_clk) begin
        clk_out_ff <= {reg_wdata[7:2], 2'b00};
      end
      if (wr_irq) begin
        irq_cfg_ff <= reg_wdata[7:2];
        lock_pin_enable_ff <= reg_wdata[LOCK_PIN_EN_BIT];
      end
      pll_lock_flag_ff <= nxt_lock_flag;
      lock_d_ff <= pll_lock_in;
      reg_rdata_ff <= nxt_rdata;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) lock_indicator_pin_ff <= 1'b0;
    else lock_indicator_pin_ff <= lock_pin_enable_ff && pll_lock_in;
  end
  // ==========================================================
  // reset pin
  // pin actively driven high, not open-drain, during por
  always_ff @(posedge clk) begin
    if (srst) begin
      manual_reset_pin_out_ff <= 1'b0;
      manual_reset_pin_oe_ff <= 1'b0;
    end else begin
      manual_reset_pin_out_ff <= por_active;
      manual_reset_pin_oe_ff <= por_active;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      hold_cnt_ff <= '0;
      pin_hi_d_ff <= 1'b0;
      manual_reset_req_ff <= 1'b0;
    end else begin
      pin_hi_d_ff <= pin_hi;
      manual_reset_req_ff <= mrst_done;
      if (!pin_hi) hold_cnt_ff <= '0;
      else if (hold_cnt_ff != '1) hold_cnt_ff <= hold_cnt_ff + 1'b1;
    end
  end
  // ==========================================================
  // readiness sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POR: if (!por_active) nxt_state = ST_WAIT;
      ST_WAIT: if (wait_cnt_ff >= wait_lim_ff) nxt_state = ST_READY;
      ST_READY: nxt_state = ST_READY;
      default: nxt_state = ST_POR;
    endcase
    if (por_active) nxt_state = ST_POR;
    else if (mrst_done) nxt_state = ST_WAIT;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ST_POR;
      wait_cnt_ff <= '0;
      wait_lim_ff <= WAIT_W'(POR_WAIT);
      dev_ready_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      dev_ready_ff <= nxt_state == ST_READY;
      if (state_ff != ST_WAIT || mrst_done) wait_cnt_ff <= '0;
      else wait_cnt_ff <= wait_cnt_ff + 1'b1;
      if (por_active) wait_lim_ff <= WAIT_W'(POR_WAIT);
      else if (mrst_done) wait_lim_ff <= WAIT_W'(MRST_WAIT);
    end
  end
  // ==========================================================
  // clock output
  rcp_clkdiv #(.DIV_W(5)) u_div (
    .clk(clk),
    .srst(srst),
    .en(clk_en),
    .div(clk_out_ff[CLK_DIV_HI:CLK_DIV_LO]),
    .clk_out_ff(buffered_clock_output)
  );
  // ==========================================================
  // checks
  property p_pin_por;
    @(posedge clk) disable iff (srst)
      por_active |=> manual_reset_pin_oe_ff && manual_reset_pin_out_ff;
  endproperty
  a_pin_por: assert property (p_pin_por)
    else $error("reset pin not held high during power-on");
  property p_clk_gate;
    @(posedge clk) disable iff (srst)
      !clk_en |=> !buffered_clock_output;
  endproperty
  a_clk_gate: assert property (p_clk_gate)
    else $error("clock output active while disabled");
  property p_sleep_off;
    @(posedge clk) disable iff (srst)
      sleep_mode [*2] |-> !buffered_clock_output;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("clock output running in sleep");
  property p_lock_set;
    @(posedge clk) disable iff (srst)
      pll_lock_in && !$past(pll_lock_in) && $past(!srst) |=>
        pll_lock_flag_ff;
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("lock flag not set on lock");
  property p_lock_hold;
    @(posedge clk) disable iff (srst)
      pll_lock_flag_ff && !lock_clr |=> pll_lock_flag_ff;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("lock flag dropped without clear");
  property p_lock_race;
    @(posedge clk) disable iff (srst)
      lock_rise && lock_clr |=> pll_lock_flag_ff;
  endproperty
  a_lock_race: assert property (p_lock_race)
    else $error("lock event lost to clear");
  property p_lock_pin;
    @(posedge clk) disable iff (srst)
      ##1 lock_indicator_pin_ff ==
        ($past(lock_pin_enable_ff) && $past(pll_lock_in));
  endproperty
  a_lock_pin: assert property (p_lock_pin)
    else $error("lock pin mismatch");
  property p_ready_por;
    @(posedge clk) disable iff (srst)
      por_active |=> !dev_ready_ff;
  endproperty
  a_ready_por: assert property (p_ready_por)
    else $error("device ready during power-on reset");
  property p_mrst_req;
    @(posedge clk) disable iff (srst)
      mrst_done |=> manual_reset_req_ff && !dev_ready_ff;
  endproperty
  a_mrst_req: assert property (p_mrst_req)
    else $error("manual reset not taken or ready kept");
  property p_short_hold;
    @(posedge clk) disable iff (srst)
      pin_hi_d_ff && !pin_hi && hold_cnt_ff < 10'(MRST_HOLD_CYC) |=>
        !manual_reset_req_ff;
  endproperty
  a_short_hold: assert property (p_short_hold)
    else $error("manual reset taken from short pulse");
  property p_lock_clear;
    @(posedge clk) disable iff (srst)
      lock_clr && !lock_rise |=> !pll_lock_flag_ff;
  endproperty
  a_lock_clear: assert property (p_lock_clear)
    else $error("lock flag not cleared by write");
  property p_lock_quiet;
    @(posedge clk) disable iff (srst)
      !lock_rise && !pll_lock_flag_ff |=> !pll_lock_flag_ff;
  endproperty
  a_lock_quiet: assert property (p_lock_quiet)
    else $error("lock flag set without lock event");
  c_lock_race: cover property (@(posedge clk) lock_rise && lock_clr);
  c_ready: cover property (@(posedge clk) $rose(dev_ready_ff));
  c_mrst: cover property (@(posedge clk) manual_reset_req_ff);
  c_clk: cover property (@(posedge clk) $rose(buffered_clock_output));
endmodule

/* bench/rcp_host.sv */
// host model pulling the manual reset pin from outside the device
`timescale 1ns/1ps
module rcp_host (
  input wire logic clk, // reference clock
  output logic drive_hi // host pulls the reset pin high
);
  // released pin settles low through the pull-down, never held stale
  // pin left floating through power-on
  initial drive_hi = 1'b0;
  // ==========================================================
  // divider plan kept by host software, the block holds no pll dividers
  // reference divider near recommended
  localparam int REF_DIV = 119;
  localparam int FB_COARSE = 100;
  localparam int FB_FINE = 50;
  // range kept, coarse plus one above fine
  function automatic logic plan_ok();
    return REF_DIV >= 64 && REF_DIV <= 169 && FB_COARSE + 1 > FB_FINE;
  endfunction
  // ==========================================================
  // manual reset
  // hold then release
  task automatic pulse(input int n);
    drive_hi = 1'b1;
    repeat (n) @(posedge clk);
    #1;
    drive_hi = 1'b0;
  endtask
endmodule

/* bench/rcp_top_tb.sv */
// self-checking bench for reset sequencing, clock output and pll lock
`timescale 1ns/1ps
module rcp_top_tb;
  import rcp_pkg::*;
  localparam int PW = 20;
  localparam int MW = 10;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic por = 1'b1;
  logic slp = 1'b0;
  logic lock = 1'b0;
  logic wr = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rd, v;
  logic pin_out, pin_oe, req, rdy, cko, lpin, host_hi;
  logic [1:0] band;
  logic [2:0] trim, mode;
  logic [4:0] dv;
  logic [1:0] codes [4] = '{2'h2, 2'h0, 2'h1, 2'h2};
  wire logic pin = pin_oe ? pin_out : host_hi;
  int err_total = 0;
  int tests_run = 0;
  int reqs = 0;
  int hp;
  always #50 clk = ~clk;
  always @(posedge clk) if (req === 1'b1) reqs++;
  rcp_host host (.clk(clk), .drive_hi(host_hi));
  rcp_top #(.POR_WAIT(PW), .MRST_WAIT(MW)) dut (.clk(clk), .srst(srst),
    .por_active(por), .sleep_mode(slp), .pll_lock_in(lock),
    .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rdata_ff(rd),
    .manual_reset_pin_in(pin), .manual_reset_pin_out_ff(pin_out),
    .manual_reset_pin_oe_ff(pin_oe), .manual_reset_req_ff(req),
    .dev_ready_ff(rdy), .buffered_clock_output(cko),
    .lock_indicator_pin_ff(lpin), .band_select_ff(band),
    .vco_trim_ff(trim), .chip_mode_ff(mode));
  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [4:0] a, input logic [7:0] exp);
    addr = a;
    cyc(1);
    chk(rd, exp, "read");
  endtask
  function automatic int exp_hp(input logic [4:0] d);
    return int'(d) + 1;
  endfunction
  // skips the half period in flight, then times a whole one
  task automatic meas(output int n);
    logic s;
    n = 0;
    for (int p = 0; p < 2; p++) begin
      s = cko;
      n = 0;
      while (cko === s && n < 200) begin
        cyc(1);
        n++;
      end
    end
  endtask
  task automatic quiet(input string m);
    logic acc;
    acc = 1'b0;
    cyc(3);
    repeat (40) begin
      acc = acc | cko;
      cyc(1);
    end
    chk({7'h00, acc}, 8'h00, m);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h17a0));
    cyc(2);
    srst = 1'b0;
    cyc(2);
    chk({5'h0, pin_oe, pin_out, pin}, 8'h07, "por pin");
    por = 1'b0;
    cyc(PW - 2);
    chk({7'h0, rdy}, 8'h00, "ready early");
    cyc(5);
    chk({7'h0, rdy}, 8'h01, "ready after por");
    chk({7'h0, host.plan_ok()}, 8'h01, "divider plan");
    chk(8'(host.REF_DIV), 8'h77, "reference divider");
    rreg(GEN_CFG_ADDR, GEN_CFG_RST);
    rreg(PLL_IRQ_ADDR, PLL_IRQ_RST);
    rreg(CLK_OUT_ADDR, CLK_OUT_RST);
    rreg(5'h05, 8'h00);
    meas(hp);
    chk(8'(hp), 8'(exp_hp(5'h0F)), "power-up clock");
    for (int i = 0; i < 6; i++) begin
      dv = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom);
      wreg(CLK_OUT_ADDR, {1'b1, dv, 2'b11});
      rreg(CLK_OUT_ADDR, {1'b1, dv, 2'b00});
      meas(hp);
      chk(8'(hp), 8'(exp_hp(dv)), "half period");
    end
    wreg(CLK_OUT_ADDR, 8'h3C);
    quiet("clock disabled");
    wreg(CLK_OUT_ADDR, 8'h80);
    slp = 1'b1;
    quiet("clock in sleep");
    slp = 1'b0;
    meas(hp);
    chk(8'(hp), 8'(exp_hp(5'h00)), "clock after sleep");
    wreg(PLL_IRQ_ADDR, 8'h01);
    lock = 1'b1;
    cyc(2);
    chk({7'h0, lpin}, 8'h01, "lock pin on");
    rreg(PLL_IRQ_ADDR, 8'h03);
    lock = 1'b0;
    cyc(2);
    chk({7'h0, lpin}, 8'h00, "lock pin off");
    rreg(PLL_IRQ_ADDR, 8'h03);
    wreg(PLL_IRQ_ADDR, 8'h02);
    rreg(PLL_IRQ_ADDR, 8'h00);
    lock = 1'b1;
    wreg(PLL_IRQ_ADDR, 8'h02);
    rreg(PLL_IRQ_ADDR, 8'h02);
    chk({7'h0, lpin}, 8'h00, "lock pin masked");
    for (int i = 0; i < 4; i++) begin
      v = {3'($urandom), codes[i], 3'(i)};
      wreg(GEN_CFG_ADDR, v);
      chk({mode, band, trim}, v, "general cfg");
      rreg(GEN_CFG_ADDR, v);
    end
    host.pulse(990);
    cyc(5);
    chk(8'(reqs), 8'h00, "short pulse");
    host.pulse(1010);
    cyc(3);
    chk(8'(reqs), 8'h01, "manual reset");
    chk({7'h0, rdy}, 8'h00, "ready in wait");
    cyc(MW + 4);
    chk({7'h0, rdy}, 8'h01, "ready after wait");
    report_and_stop();
  end
endmodule
